// *** logic/pfc_pkg.sv ***
`default_nettype none
package pfc_pkg;

  // Port geometry.
  localparam int NUM_PORTS = 10;
  localparam int PORT_W = 8;
  localparam int NUM_PINS = NUM_PORTS * PORT_W;

  // Configuration planes as software addresses them.
  localparam logic [1:0] PLANE_BIT0 = 2'h0;
  localparam logic [1:0] PLANE_BIT1 = 2'h1;
  localparam logic [1:0] PLANE_BIT2 = 2'h2;

  // Configuration codes, written {bit2, bit1, bit0}.
  localparam logic [2:0] CODE_IN_TTL = 3'h0;
  localparam logic [2:0] CODE_IN_CMOS = 3'h4;
  localparam logic [2:0] CODE_OUT_PP = 3'h2;
  localparam logic [2:0] CODE_OUT_OD = 3'h6;
  localparam logic [2:0] CODE_AF_IN_TTL = 3'h1;
  localparam logic [2:0] CODE_AF_IN_CMOS = 3'h5;
  localparam logic [2:0] CODE_AF_OUT_PP = 3'h3;
  localparam logic [2:0] CODE_AF_BIDIR = 3'h7;

  // Fixed pin characteristics, one bit per pin, port 9 in the top byte.
  localparam logic [NUM_PINS-1:0] SCHMITT_MASK = 80'hff_ff_ff_3f_f7_db_f6_33_00_00;
  localparam logic [NUM_PINS-1:0] PURE_OD_MASK = 80'h00_00_00_00_00_c0_00_0c_00_00;
  localparam logic [NUM_PINS-1:0] PULLUP_MASK = 80'hff_ff_ff_3f_08_2e_fe_f3_00_00;
  localparam logic [NUM_PINS-1:0] ANALOG_MASK = 80'h00_ff_ff_00_00_00_00_00_00_00;

  // Reset value of each configuration plane.
  localparam logic [NUM_PINS-1:0] RST_PLANE0 = 80'h00_00_00_00_00_00_00_00_00_00;
  localparam logic [NUM_PINS-1:0] RST_PLANE1 = 80'hff_fc_00_00_00_02_00_00_ff_ff;
  localparam logic [NUM_PINS-1:0] RST_PLANE2 = 80'hff_fc_00_00_08_26_08_cc_ff_ff;

  // Pin positions of the named alternate functions.
  localparam int PIN_SERIAL0_RX = 5 * 8 + 2;
  localparam int PIN_SERIAL0_TX = 5 * 8 + 3;
  localparam int PIN_TIMER0_CAP_CMP = 3 * 8 + 2;
  localparam int PIN_TIMER0_CLK_SS = 3 * 8 + 4;
  localparam int PIN_SPI_SCK = 3 * 8 + 7;
  localparam int BASE_EXT_AD = 0 * 8;
  localparam int BASE_EXT_HI = 1 * 8;
  localparam int BASE_CONV0 = 7 * 8;

  // Decoded per-pin controls.
  typedef struct packed {
    logic drive_en;
    logic open_drain;
    logic af_sel;
    logic af_bidir;
    logic cmos_level;
    logic analog_en;
  } pfc_pin_ctl_t;

  // Pad-side signals of one pin.
  typedef struct packed {
    logic out;
    logic oe;
    logic pullup_en;
    logic cmos_sel;
    logic analog_en;
  } pfc_pad_t;

endpackage
`default_nettype wire

// *** logic/pfc_cfg_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
// Turns one pin's three configuration bits and its fixed cell traits into controls.
module pfc_cfg_decode (
  // Configuration code and cell traits.
  input wire logic [2:0] cfg,
  input wire logic has_schmitt,
  input wire logic pure_od,
  input wire logic analog_cap,
  // Decoded controls.
  output pfc_pkg::pfc_pin_ctl_t ctl
);

  // Bit0 picks the alternate function, bit1 the output stage, bit2 the level or drive type.
  always_comb begin
    ctl.af_sel = cfg[0];
    ctl.analog_en = analog_cap && (cfg == pfc_pkg::CODE_AF_BIDIR);
    ctl.af_bidir = (cfg == pfc_pkg::CODE_AF_BIDIR) && !analog_cap;
    ctl.drive_en = cfg[1] && !(cfg[0] && cfg[2]);
    // Pure open-drain cells ignore push-pull, other cells use bit2 for open drain when bit0 is clear.
    ctl.open_drain = pure_od || (cfg[2] && !cfg[0]);
    // A Schmitt stage or an analog connection overrides the level choice.
    ctl.cmos_level = cfg[2] && !has_schmitt && !ctl.analog_en;
  end

endmodule // pfc_cfg_decode
`default_nettype wire

// *** logic/pfc_cfg_store.sv ***
`timescale 1ns/1ps
`default_nettype none
// Holds the three configuration planes of every port, written one port byte at a time.
module pfc_cfg_store #(
  parameter int NUM_PORTS = pfc_pkg::NUM_PORTS,
  parameter int PORT_W = pfc_pkg::PORT_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  // Write request.
  input wire logic wr_en,
  input wire logic [3:0] wr_port,
  input wire logic [1:0] wr_plane,
  input wire logic [PORT_W-1:0] wr_data,
  // Configuration planes, and the same with a write in flight already applied.
  output logic [NUM_PORTS*PORT_W-1:0] plane_reg [3],
  output logic [NUM_PORTS*PORT_W-1:0] plane_view [3]
);

  // Each plane and port byte is its own group of flip-flops, so bits stay independent.
  for (genvar p = 0; p < 3; p++) begin : g_plane
    for (genvar n = 0; n < NUM_PORTS; n++) begin : g_port
      // A constant, so the asynchronous reset branch loads nothing but constants.
      localparam logic [PORT_W-1:0] RST_VAL =
        (p == 0) ? pfc_pkg::RST_PLANE0[n*PORT_W +: PORT_W] :
        (p == 1) ? pfc_pkg::RST_PLANE1[n*PORT_W +: PORT_W] :
                   pfc_pkg::RST_PLANE2[n*PORT_W +: PORT_W];
      logic hit;
      assign hit = wr_en && (wr_port == 4'(n)) && (wr_plane == 2'(p));
      // Reset puts each pin in its documented default mode.
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          plane_reg[p][n*PORT_W +: PORT_W] <= RST_VAL;
        end else if (hit) begin
          plane_reg[p][n*PORT_W +: PORT_W] <= wr_data;
        end
      end
      // Write-through view lets the pads follow on the edge that takes the write.
      assign plane_view[p][n*PORT_W +: PORT_W] = hit ? wr_data :
                                                 plane_reg[p][n*PORT_W +: PORT_W];
    end
  end

endmodule // pfc_cfg_store
`default_nettype wire

// *** logic/pfc_port_pins.sv ***
`timescale 1ns/1ps
`default_nettype none
module pfc_port_pins #(
  parameter int NUM_PORTS = pfc_pkg::NUM_PORTS,
  parameter int PORT_W = pfc_pkg::PORT_W
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration write port.
  input wire logic cfg_wr_en,
  input wire logic [3:0] cfg_wr_port,
  input wire logic [1:0] cfg_wr_plane,
  input wire logic [PORT_W-1:0] cfg_wr_data,
  // General-purpose data.
  input wire logic [NUM_PORTS*PORT_W-1:0] gpio_data_out,
  output logic [NUM_PORTS*PORT_W-1:0] gpio_data_in,
  // Pads.
  input wire logic [NUM_PORTS*PORT_W-1:0] pad_in,
  output logic [NUM_PORTS*PORT_W-1:0] pad_out,
  output logic [NUM_PORTS*PORT_W-1:0] pad_oe,
  output logic [NUM_PORTS*PORT_W-1:0] weak_pullup_en,
  output logic [NUM_PORTS*PORT_W-1:0] pad_cmos_sel,
  output logic [NUM_PORTS*PORT_W-1:0] pad_analog_en,
  // External memory interface.
  input wire logic ext_mem_en,
  input wire logic [7:0] ext_mem_addr_data_out,
  input wire logic ext_mem_addr_data_oe,
  input wire logic [7:0] ext_mem_addr_high,
  output logic [7:0] ext_mem_addr_data_in,
  // First serial interface.
  input wire logic serial0_en,
  input wire logic serial0_tx_data,
  output logic serial0_rx_data,
  // SPI.
  input wire logic spi_en,
  input wire logic spi_master,
  input wire logic spi_sck_out,
  output logic spi_sck_in,
  output logic spi_slave_select,
  // Extended timer 0.
  input wire logic timer0_en,
  input wire logic timer0_compare_a,
  output logic timer0_capture_a,
  output logic timer0_ext_clock_in,
  // Wake-up controller.
  input wire logic wake_en,
  output logic wake_line_0,
  // Analog converter 0 channel switches.
  output logic [7:0] converter0_channel
);

  localparam int NP = NUM_PORTS * PORT_W;

  // The characteristic masks and pin positions are laid out for ten eight-bit ports.
  if (NUM_PORTS != pfc_pkg::NUM_PORTS || PORT_W != pfc_pkg::PORT_W) begin : g_bad_geometry
    $error("pfc_port_pins: port geometry must match the fixed pin map");
  end

  logic [NP-1:0] plane_reg [3];
  logic [NP-1:0] plane_view [3];
  pfc_pkg::pfc_pin_ctl_t ctl [NP];
  logic [NP-1:0] af_out;
  logic [NP-1:0] af_oe;
  logic [NP-1:0] af_in_ok;
  pfc_pkg::pfc_pad_t pad_next [NP];

  // Configuration planes.
  pfc_cfg_store #(
    .NUM_PORTS(NUM_PORTS),
    .PORT_W(PORT_W)
  ) u_store (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(cfg_wr_en),
    .wr_port(cfg_wr_port),
    .wr_plane(cfg_wr_plane),
    .wr_data(cfg_wr_data),
    .plane_reg(plane_reg),
    .plane_view(plane_view)
  );

  // Per-pin decode and pad control, one copy per pin.
  for (genvar i = 0; i < NP; i++) begin : g_pin
    logic value;
    logic want_drive;

    pfc_cfg_decode u_dec (
      .cfg({plane_view[2][i], plane_view[1][i], plane_view[0][i]}),
      .has_schmitt(pfc_pkg::SCHMITT_MASK[i]),
      .pure_od(pfc_pkg::PURE_OD_MASK[i]),
      .analog_cap(pfc_pkg::ANALOG_MASK[i]),
      .ctl(ctl[i])
    );

    // Only the selected source reaches the pin: GPIO data or the one alternate output.
    assign value = ctl[i].af_sel ? af_out[i] : gpio_data_out[i];
    // A bidirectional function drives only while its peripheral asks to.
    assign want_drive = ctl[i].drive_en || (ctl[i].af_bidir && af_oe[i]);
    // An alternate input is blocked while the pin is in alternate push-pull output mode or is analog.
    assign af_in_ok[i] = !(ctl[i].af_sel && ctl[i].drive_en) && !ctl[i].analog_en;

    // Open drain keeps the low side only, so a high value releases the pin.
    always_comb begin
      pad_next[i].out = ctl[i].open_drain ? 1'b0 : value;
      pad_next[i].oe = want_drive && (!ctl[i].open_drain || !value);
      // Pull-up only where the cell has one, and only while the pin is not in an output code (drive_en clear).
      pad_next[i].pullup_en = pfc_pkg::PULLUP_MASK[i] && !ctl[i].drive_en &&
                              !ctl[i].analog_en;
      pad_next[i].cmos_sel = ctl[i].cmos_level;
      pad_next[i].analog_en = ctl[i].analog_en;
    end

    // Pad flip-flops; every pad output comes straight from here.
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        pad_out[i] <= 1'b0;
        pad_oe[i] <= 1'b0;
        weak_pullup_en[i] <= 1'b0;
        pad_cmos_sel[i] <= 1'b0;
        pad_analog_en[i] <= 1'b0;
      end else begin
        pad_out[i] <= pad_next[i].out;
        pad_oe[i] <= pad_next[i].oe;
        weak_pullup_en[i] <= pad_next[i].pullup_en;
        pad_cmos_sel[i] <= pad_next[i].cmos_sel;
        pad_analog_en[i] <= pad_next[i].analog_en;
      end
    end

    // Digital read-back is forced low while the pin is an analog input.
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        gpio_data_in[i] <= 1'b0;
      end else begin
        gpio_data_in[i] <= pad_in[i] && !ctl[i].analog_en;
      end
    end
  end

  // Alternate output sources. Each pin has one assignment at most, which is why
  // two outputs can never meet on a pin; unlisted pins have no alternate output.
  always_comb begin
    af_out = '0;
    af_oe = '0;
    for (int b = 0; b < 8; b++) begin
      // Port 0 is multiplexed address/data, driven while the bus cycle says so.
      af_out[pfc_pkg::BASE_EXT_AD + b] = ext_mem_addr_data_out[b];
      af_oe[pfc_pkg::BASE_EXT_AD + b] = ext_mem_en && ext_mem_addr_data_oe;
      // Port 1 carries the high address and drives in bidirectional mode whenever ext_mem_en is set.
      af_out[pfc_pkg::BASE_EXT_HI + b] = ext_mem_addr_high[b];
      af_oe[pfc_pkg::BASE_EXT_HI + b] = ext_mem_en;
    end
    af_out[pfc_pkg::PIN_SERIAL0_TX] = serial0_tx_data;
    af_oe[pfc_pkg::PIN_SERIAL0_TX] = serial0_en;
    af_out[pfc_pkg::PIN_TIMER0_CAP_CMP] = timer0_compare_a;
    af_oe[pfc_pkg::PIN_TIMER0_CAP_CMP] = timer0_en;
    // In code 111 the SPI clock leaves the pin only when the SPI is master; code 011 always drives it.
    af_out[pfc_pkg::PIN_SPI_SCK] = spi_sck_out;
    af_oe[pfc_pkg::PIN_SPI_SCK] = spi_en && spi_master;
  end

  // External memory data in: sampled only while port 0 is in its bidirectional mode.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_mem_addr_data_in <= 8'h00;
    end else begin
      for (int b = 0; b < 8; b++) begin
        ext_mem_addr_data_in[b] <= ext_mem_en && ctl[pfc_pkg::BASE_EXT_AD + b].af_bidir &&
                                   pad_in[pfc_pkg::BASE_EXT_AD + b];
      end
    end
  end

  // Serial receive data follows the pin as soon as the serial interface is on, in every code but 011.
  // No code 101 is needed for this; that code only adds the level choice.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serial0_rx_data <= 1'b1;
    end else begin
      serial0_rx_data <= serial0_en && af_in_ok[pfc_pkg::PIN_SERIAL0_RX] ?
                         pad_in[pfc_pkg::PIN_SERIAL0_RX] : 1'b1;
    end
  end

  // SPI clock input for a slave and the shared wake line on the same pin.
  // The wake line stays connected even while the master drives the clock out.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      spi_sck_in <= 1'b0;
      wake_line_0 <= 1'b0;
    end else begin
      spi_sck_in <= spi_en && !spi_master && af_in_ok[pfc_pkg::PIN_SPI_SCK] &&
                    pad_in[pfc_pkg::PIN_SPI_SCK];
      wake_line_0 <= wake_en && !ctl[pfc_pkg::PIN_SPI_SCK].analog_en &&
                     pad_in[pfc_pkg::PIN_SPI_SCK];
    end
  end

  // Timer 0 capture A is cut off while the shared pin is in alternate push-pull output mode for compare A.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer0_capture_a <= 1'b0;
    end else begin
      timer0_capture_a <= timer0_en && af_in_ok[pfc_pkg::PIN_TIMER0_CAP_CMP] &&
                          pad_in[pfc_pkg::PIN_TIMER0_CAP_CMP];
    end
  end

  // One pin feeds two inputs at once; both are inputs so nothing contends.
  // Slave select idles high so a disabled SPI never sees itself selected.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer0_ext_clock_in <= 1'b0;
      spi_slave_select <= 1'b1;
    end else begin
      timer0_ext_clock_in <= timer0_en && af_in_ok[pfc_pkg::PIN_TIMER0_CLK_SS] &&
                             pad_in[pfc_pkg::PIN_TIMER0_CLK_SS];
      spi_slave_select <= (spi_en && af_in_ok[pfc_pkg::PIN_TIMER0_CLK_SS]) ?
                          pad_in[pfc_pkg::PIN_TIMER0_CLK_SS] : 1'b1;
    end
  end

  // Converter channel switches close only on explicit code 111, never implicitly.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      converter0_channel <= 8'h00;
    end else begin
      for (int b = 0; b < 8; b++) begin
        converter0_channel[b] <= ctl[pfc_pkg::BASE_CONV0 + b].analog_en;
      end
    end
  end

endmodule // pfc_port_pins
`default_nettype wire

// *** tb/pfc_port_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// Watches the port block's pins and peripheral lines for fixed wiring and timing.
module pfc_port_monitor #(
  parameter int NUM_PORTS = 10,
  parameter int PORT_W = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Pads and sampled data.
  input wire logic [NUM_PORTS*PORT_W-1:0] pad_in,
  input wire logic [NUM_PORTS*PORT_W-1:0] pad_out,
  input wire logic [NUM_PORTS*PORT_W-1:0] pad_oe,
  input wire logic [NUM_PORTS*PORT_W-1:0] weak_pullup_en,
  input wire logic [NUM_PORTS*PORT_W-1:0] pad_cmos_sel,
  input wire logic [NUM_PORTS*PORT_W-1:0] pad_analog_en,
  input wire logic [NUM_PORTS*PORT_W-1:0] gpio_data_in,
  // Peripheral lines.
  input wire logic ext_mem_en,
  input wire logic [7:0] ext_mem_addr_data_in,
  input wire logic serial0_en,
  input wire logic serial0_rx_data,
  input wire logic spi_en,
  input wire logic spi_slave_select,
  input wire logic timer0_en,
  input wire logic timer0_ext_clock_in,
  input wire logic wake_en,
  input wire logic wake_line_0,
  input wire logic [7:0] converter0_channel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // The edge after reset still shows reset values, so sampled-input checks skip it.
  sequence settled;
    !$past(rst) ##0 $stable(pad_analog_en);
  endsequence
  sequence wake_armed;
    wake_en ##0 !rst;
  endsequence

  pure_od_low_a: assert property ((pad_out & pfc_pkg::PURE_OD_MASK) == '0)
    else $error("pure open-drain pin driven high");
  pullup_fixed_a: assert property ((weak_pullup_en & ~pfc_pkg::PULLUP_MASK) == '0)
    else $error("pull-up on a pin without one");
  schmitt_level_a: assert property
    ((pad_cmos_sel & (pfc_pkg::SCHMITT_MASK | pad_analog_en)) == '0)
    else $error("level select on schmitt or analog pin");
  analog_map_a: assert property ((pad_analog_en & ~pfc_pkg::ANALOG_MASK) == '0
    && converter0_channel == pad_analog_en[63:56])
    else $error("analog switch mismatch");
  reset_input_a: assert property ($past(rst) |-> pad_oe[39:38] == 2'h0)
    else $error("port 4 top bits driven after reset");
  wake_follow_a: assert property (wake_armed |=> wake_line_0 == $past(pad_in[31]))
    else $error("wake line does not follow its pin");
  ext_mem_idle_a: assert property (!ext_mem_en |=> ext_mem_addr_data_in == 8'h00)
    else $error("memory bus input while disabled");
  periph_idle_a: assert property (!serial0_en && !spi_en && !timer0_en |=>
    serial0_rx_data && spi_slave_select && !timer0_ext_clock_in)
    else $error("disabled peripheral input not idle");
  gpio_sample_a: assert property (settled |->
    gpio_data_in == ($past(pad_in) & ~pad_analog_en))
    else $error("sampled pin data mismatch");
endmodule // pfc_port_monitor
`default_nettype wire

// *** tb/pfc_pin_env.sv ***
`timescale 1ns/1ps
`default_nettype none
// Board side of the pins: drivers, external pull-ups on pure open-drain pins, floating rest.
module pfc_pin_env (
  // Clock.
  input wire logic ref_clk,
  // Device pad side.
  input wire logic [79:0] pad_out,
  input wire logic [79:0] pad_oe,
  input wire logic [79:0] weak_pullup_en,
  // Board drivers.
  input wire logic [79:0] ext_oe,
  input wire logic [79:0] ext_val,
  // Resolved pin level.
  output logic [79:0] pad_in
);
  logic [79:0] flt = 80'h0;

  // A released pin with no pull flips every cycle, so it never reads as a kept value.
  always_ff @(posedge ref_clk) begin
    flt <= ~flt;
  end

  // A low from either side wins; the pure open-drain pins carry a board pull-up.
  assign pad_in = (pad_oe & pad_out & (~ext_oe | ext_val)) | (~pad_oe & ext_oe & ext_val)
    | (~pad_oe & ~ext_oe & (weak_pullup_en | pfc_pkg::PURE_OD_MASK | flt));
endmodule // pfc_pin_env
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr_en = 1'b0;
  logic [3:0] cfg_wr_port = 4'h0;
  logic [1:0] cfg_wr_plane = 2'h0;
  logic [7:0] cfg_wr_data = 8'h00, em_ado = 8'h00, em_hi = 8'h00, em_adi, conv;
  logic [79:0] gpo = 80'h0, ext_oe = 80'h0, ext_val = 80'h0, pin_q = 80'h0;
  logic [79:0] g_in, p_in, p_out, p_oe, p_pu, p_cm, p_an;
  logic em_en = 1'b0, em_oe = 1'b0, s0_en = 1'b0, s0_tx = 1'b0, spi_en = 1'b0;
  logic spi_m = 1'b0, sck_o = 1'b0, t0_en = 1'b0, t0_cmp = 1'b0, wk_en = 1'b0;
  logic s0_rx, sck_in, ss, cap, eclk, wake;
  logic [79:0] mp [3];
  integer seed = 32'h39fa;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int r;

  pfc_port_pins pfc_port_pins_inst (
    .ref_clk(ref_clk), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_wr_port(cfg_wr_port),
    .cfg_wr_plane(cfg_wr_plane), .cfg_wr_data(cfg_wr_data), .gpio_data_out(gpo),
    .gpio_data_in(g_in), .pad_in(p_in), .pad_out(p_out), .pad_oe(p_oe),
    .weak_pullup_en(p_pu), .pad_cmos_sel(p_cm), .pad_analog_en(p_an),
    .ext_mem_en(em_en), .ext_mem_addr_data_out(em_ado), .ext_mem_addr_data_oe(em_oe),
    .ext_mem_addr_high(em_hi), .ext_mem_addr_data_in(em_adi), .serial0_en(s0_en),
    .serial0_tx_data(s0_tx), .serial0_rx_data(s0_rx), .spi_en(spi_en), .spi_master(spi_m),
    .spi_sck_out(sck_o), .spi_sck_in(sck_in), .spi_slave_select(ss), .timer0_en(t0_en),
    .timer0_compare_a(t0_cmp), .timer0_capture_a(cap), .timer0_ext_clock_in(eclk),
    .wake_en(wk_en), .wake_line_0(wake), .converter0_channel(conv));
  pfc_pin_env pfc_pin_env_inst (.ref_clk(ref_clk), .pad_out(p_out), .pad_oe(p_oe),
    .weak_pullup_en(p_pu), .ext_oe(ext_oe), .ext_val(ext_val), .pad_in(p_in));

  // Free-running clock.
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Pin level as the design samples it, plus a hang guard.
  always @(posedge ref_clk) begin
    pin_q <= p_in;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cv(input logic [79:0] got, input logic [79:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic go(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // One plane byte per write; absent ports and plane 3 leave the model alone.
  task automatic wr(input logic [3:0] p, input logic [1:0] pl, input logic [7:0] d);
    @(posedge ref_clk);
    cfg_wr_en <= 1'b1;
    cfg_wr_port <= p;
    cfg_wr_plane <= pl;
    cfg_wr_data <= d;
    @(posedge ref_clk);
    cfg_wr_en <= 1'b0;
    if (p < 4'ha && pl != 2'h3) mp[pl][p*8 +: 8] = d;
    #1;
  endtask

  task automatic setc(input logic [3:0] p, input logic [7:0] m, input logic [2:0] c);
    for (int k = 0; k < 3; k++) begin
      wr(p, 2'(k), (mp[k][p*8 +: 8] & ~m) | (c[k] ? m : 8'h00));
    end
  endtask

  // Expected pads for plain port codes, built from the three planes.
  task automatic chk_gpio;
    logic [79:0] om, od, pp, inm;
    om = mp[1] & ~mp[0];
    od = om & (mp[2] | pfc_pkg::PURE_OD_MASK);
    pp = om & ~od;
    inm = ~mp[1];
    cv(p_oe, pp | (od & ~gpo));
    cv(p_out, gpo & ~(mp[2] | pfc_pkg::PURE_OD_MASK));
    cv(p_cm, mp[2] & ~pfc_pkg::SCHMITT_MASK);
    cv(p_pu & inm, pfc_pkg::PULLUP_MASK & inm);
    cv(g_in, pin_q);
  endtask

  // Main sequence: reset modes, random plain traffic, then each alternate function.
  initial begin
    mp[0] = pfc_pkg::RST_PLANE0;
    mp[1] = pfc_pkg::RST_PLANE1;
    mp[2] = pfc_pkg::RST_PLANE2;
    gpo = {$random(seed), $random(seed), 16'h5a3c};
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    go(1);
    chk_gpio();
    for (int p = 0; p < 10; p++) begin
      wr(4'(p), 2'h0, 8'h00);
    end
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      @(posedge ref_clk);
      gpo <= {$random(seed), $random(seed), r[31:16]};
      ext_oe <= {r, r[15:0], r};
      ext_val <= {$random(seed), r[15:0], $random(seed)};
      {em_en, em_oe, s0_en, s0_tx, spi_en, spi_m, sck_o, t0_en, t0_cmp, wk_en} <= r[9:0];
      em_ado <= r[23:16];
      em_hi <= r[31:24];
      wr(r[3:0], r[5:4], (r[5:4] == 2'h0) ? 8'h00 : r[13:6]);
      chk_gpio();
    end
    @(posedge ref_clk);
    {em_en, em_oe, spi_en, spi_m, t0_en, wk_en, s0_en} <= 7'h03;
    ext_oe <= 80'h0;
    setc(4'h5, 8'h08, 3'h1);
    cv(p_oe[43], 1'b0);
    setc(4'h5, 8'h08, 3'h3);
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      s0_tx <= v[0];
      go(1);
      cv({p_oe[43], p_out[43]}, {1'b1, v[0]});
    end
    setc(4'h5, 8'h04, 3'h5);
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      s0_en <= ~v[0];
      ext_oe[42] <= 1'b1;
      ext_val[42] <= 1'b0;
      go(2);
      cv(s0_rx, v[0]);
    end
    setc(4'h0, 8'hff, 3'h7);
    setc(4'h1, 8'hff, 3'h7);
    @(posedge ref_clk);
    {em_en, em_oe, em_hi, em_ado} <= {2'h3, 16'hc3a5};
    go(1);
    cv({p_oe[15:0], p_out[15:0]}, {16'hffff, 16'hc3a5});
    @(posedge ref_clk);
    em_oe <= 1'b0;
    ext_oe[7:0] <= 8'hff;
    ext_val[7:0] <= 8'h96;
    go(2);
    cv({p_oe[7:0], em_adi}, 16'h0096);
    cv(conv, 8'h00);
    setc(4'h7, 8'hff, 3'h7);
    cv({conv, p_an[63:56], p_cm[63:56], g_in[63:56]}, 32'hffff_0000);
    setc(4'h3, 8'h80, 3'h7);
    setc(4'h3, 8'h04, 3'h3);
    setc(4'h3, 8'h10, 3'h0);
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      {spi_en, spi_m, t0_en, sck_o, t0_cmp, ext_oe[31]} <= {3'h7, v[0], v[0], 1'b0};
      {ext_oe[28], ext_val[28], ext_oe[26], ext_val[26]} <= {1'b1, v[0], 2'h3};
      go(2);
      cv({p_oe[31], p_out[31], p_oe[26], p_out[26], cap}, {1'b1, v[0], 1'b1, v[0], 1'b0});
      cv({eclk, ss}, {v[0], v[0]});
      @(posedge ref_clk);
      {spi_m, ext_oe[31], ext_val[31]} <= {2'h1, v[0]};
      go(2);
      cv({p_oe[31], sck_in}, {1'b0, v[0]});
      cv(wake, v[0]);
    end
    report_and_stop();
  end
endmodule // tb_top

bind pfc_port_pins pfc_port_monitor #(.NUM_PORTS(NUM_PORTS), .PORT_W(PORT_W)) mon_inst (
  .ref_clk(ref_clk), .rst(rst), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
  .weak_pullup_en(weak_pullup_en), .pad_cmos_sel(pad_cmos_sel),
  .pad_analog_en(pad_analog_en), .gpio_data_in(gpio_data_in), .ext_mem_en(ext_mem_en),
  .ext_mem_addr_data_in(ext_mem_addr_data_in), .serial0_en(serial0_en),
  .serial0_rx_data(serial0_rx_data), .spi_en(spi_en), .spi_slave_select(spi_slave_select),
  .timer0_en(timer0_en), .timer0_ext_clock_in(timer0_ext_clock_in), .wake_en(wake_en),
  .wake_line_0(wake_line_0), .converter0_channel(converter0_channel));
`default_nettype wire
